// >>> src/lsag_top.sv
// line scan acquisition gate with apb registers and encoder rate tools
`timescale 1ns/100ps
`include "lsag_defs.svh"
module lsag_top (
   input wire logic clk_sys,                  // 20 MHz system clock
   input wire logic resetn,                   // async reset, active low
   input wire logic psel,                     // apb select
   input wire logic penable,                  // apb access phase
   input wire logic pwrite,                   // apb direction
   input wire logic [7:0] paddr,              // apb byte address
   input wire logic [31:0] pwdata,            // apb write data
   output logic [31:0] prdata,                // apb read data
   output logic pready,                       // apb ready
   output logic pslverr,                      // apb error, unmapped
   input wire logic line_boundary,            // pulse, camera line start
   input wire logic pix_valid,                // line data word valid
   input wire logic [31:0] pix_data,          // line data word
   input wire logic line_input_one_event,     // hardware event pulse
   input wire logic line_input_two_event,     // hardware event pulse
   input wire logic encoder_event,            // motion encoder pulse
   output logic camera_trigger,               // pulse to camera
   output logic gate_open,                    // acquisition gate
   output logic dma_valid,                    // output word valid
   output lsag_pkg::lsag_word_t dma_word,     // word and line slot
   output logic buf_release,                  // pulse, buffer handed over
   output lsag_pkg::lsag_release_t buf_info   // released buffer info
);
   // ==========================================================
   // register file
   logic [`LSAG_CFG_W-1:0] cfg_r;
   logic [15:0] lines_per_scan, buf_cap_r, div_n_r, mul_r, div_r;
   logic [3:0] cmd_r;
   logic [31:0] prdata_r;
   logic wr_en, setup, hit;
   lsag_pkg::lsag_state_t state_r;
   logic scan_active_r, finish_pend_r, acq_on_r;
   logic [15:0] scan_lines_r, buf_lines_r, buf_id_r;

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a[1:0] == 2'h0) && (a <= `LSAG_OFS_STATUS);
   endfunction

   assign setup = psel && !penable;
   assign wr_en = psel && penable && pwrite && mapped(paddr);
   assign hit = mapped(paddr);
   assign pready = 1'b1;
   assign pslverr = psel && penable && !hit;
   assign prdata = prdata_r;

   // configuration writes take effect at the access edge
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cfg_r <= `LSAG_CFG_RST;
         lines_per_scan <= `LSAG_LINES_RST;
         buf_cap_r <= `LSAG_BUFCAP_RST;
         div_n_r <= `LSAG_RATE_RST;
         mul_r <= `LSAG_RATE_RST;
         div_r <= `LSAG_RATE_RST;
      end else if (wr_en) begin
         case (paddr)
            `LSAG_OFS_CFG: cfg_r <= pwdata[`LSAG_CFG_W-1:0];
            `LSAG_OFS_LINES: lines_per_scan <= pwdata[15:0];
            `LSAG_OFS_BUFCAP: buf_cap_r <= pwdata[15:0];
            `LSAG_OFS_DIVN: div_n_r <= pwdata[15:0];
            `LSAG_OFS_MUL: mul_r <= pwdata[15:0];
            `LSAG_OFS_DIV: div_r <= pwdata[15:0];
            default: ;
         endcase
      end
   end

   // command bits are one-cycle pulses, nothing is stored
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn)
         cmd_r <= 4'h0;
      else if (wr_en && paddr == `LSAG_OFS_CMD)
         cmd_r <= pwdata[3:0];
      else
         cmd_r <= 4'h0;
   end

   // read data latched in setup so it comes from a flop in access
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         prdata_r <= 32'h0;
      end else if (setup) begin
         case (paddr)
            `LSAG_OFS_CFG: prdata_r <= {25'h0, cfg_r};
            `LSAG_OFS_LINES: prdata_r <= {16'h0, lines_per_scan};
            `LSAG_OFS_BUFCAP: prdata_r <= {16'h0, buf_cap_r};
            `LSAG_OFS_DIVN: prdata_r <= {16'h0, div_n_r};
            `LSAG_OFS_MUL: prdata_r <= {16'h0, mul_r};
            `LSAG_OFS_DIV: prdata_r <= {16'h0, div_r};
            `LSAG_OFS_STATUS: prdata_r <= {buf_lines_r, 10'h0, state_r,
               finish_pend_r, scan_active_r, acq_on_r, gate_open};
            default: prdata_r <= 32'h0;
         endcase
      end
   end

   // ==========================================================
   // trigger qualification
   lsag_pkg::lsag_bsrc_t bsrc;
   lsag_pkg::lsag_fsrc_t fsrc;
   logic begin_evt, finish_evt, halt, arm, count_done, close_now;
   assign bsrc = lsag_pkg::lsag_bsrc_t'(cfg_r[`LSAG_CFG_BSRC_LO +: 2]);
   assign fsrc = lsag_pkg::lsag_fsrc_t'(cfg_r[`LSAG_CFG_FSRC_LO +: 2]);
   assign arm = cmd_r[`LSAG_CMD_ARM];
   assign halt = cmd_r[`LSAG_CMD_HALT];
   assign begin_evt = cmd_r[`LSAG_CMD_BEGIN]
      || (bsrc == lsag_pkg::BSRC_LINE_ONE && line_input_one_event)
      || (bsrc == lsag_pkg::BSRC_LINE_TWO && line_input_two_event);
   // finish command or selected line, only while scanning
   assign finish_evt = scan_active_r && (cmd_r[`LSAG_CMD_FINISH]
      || (fsrc == lsag_pkg::FSRC_LINE_ONE && line_input_one_event)
      || (fsrc == lsag_pkg::FSRC_LINE_TWO && line_input_two_event));
   // last programmed line completes at this boundary
   assign count_done = fsrc == lsag_pkg::FSRC_COUNT
      && lines_per_scan != 16'h0 && scan_lines_r + 16'h1 >= lines_per_scan;
   assign close_now = line_boundary && (count_done || finish_pend_r);

   // set wins: a finish on a boundary cycle waits for the next one
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn)
         finish_pend_r <= 1'b0;
      else if (finish_evt)
         finish_pend_r <= 1'b1;
      else if (!scan_active_r || line_boundary)
         finish_pend_r <= 1'b0;
   end

   // acquisition armed by software until halted
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn)
         acq_on_r <= 1'b0;
      else if (halt)
         acq_on_r <= 1'b0;
      else if (arm)
         acq_on_r <= 1'b1;
   end

   // ==========================================================
   // gate state machine
   // immediate source bypasses the begin trigger
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state_r <= lsag_pkg::ST_IDLE;
      end else if (halt) begin
         state_r <= lsag_pkg::ST_IDLE;
      end else begin
         case (state_r)
            lsag_pkg::ST_IDLE:
               if (arm) begin
                  state_r <= (bsrc == lsag_pkg::BSRC_IMMEDIATE) ?
                     lsag_pkg::ST_PEND : lsag_pkg::ST_ARMED;
               end
            lsag_pkg::ST_ARMED:
               if (begin_evt) begin
                  state_r <= lsag_pkg::ST_PEND;
               end
            lsag_pkg::ST_PEND:
               // open on the next line boundary
               if (line_boundary) begin
                  state_r <= lsag_pkg::ST_SCAN;
               end
            lsag_pkg::ST_SCAN:
               if (close_now) begin
                  state_r <= (bsrc == lsag_pkg::BSRC_IMMEDIATE) ?
                     lsag_pkg::ST_PEND : lsag_pkg::ST_ARMED;
               end
            default: state_r <= lsag_pkg::ST_IDLE;
         endcase
      end
   end

   // scan flag follows the gate exactly
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn)
         scan_active_r <= 1'b0;
      else if (halt || (state_r == lsag_pkg::ST_SCAN && close_now))
         scan_active_r <= 1'b0;
      else if (state_r == lsag_pkg::ST_PEND && line_boundary)
         scan_active_r <= 1'b1;
   end
   // gate stays open until the scan closes at a line boundary or a halt
   assign gate_open = scan_active_r;

   // ==========================================================
   // buffer filling
   logic line_done, full_now, open_now;
   assign open_now = state_r == lsag_pkg::ST_PEND && line_boundary && !halt;
   // a line is complete only when the next boundary arrives
   assign line_done = scan_active_r && line_boundary && !halt;
   // release when no slot remains for another line
   assign full_now = line_done && buf_lines_r + 16'h1 >= buf_cap_r;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         scan_lines_r <= 16'h0;
         buf_lines_r <= 16'h0;
         buf_id_r <= 16'h0;
         buf_release <= 1'b0;
         buf_info <= '0;
      end else begin
         buf_release <= 1'b0;
         if (open_now) begin
            // every scan begins in a new buffer
            scan_lines_r <= 16'h0;
            buf_lines_r <= 16'h0;
         end else if (line_done && (close_now || full_now)) begin
            // final or full buffer leaves at once
            buf_release <= 1'b1;
            buf_info <= '{lines: buf_lines_r + 16'h1, buf_id: buf_id_r};
            buf_id_r <= buf_id_r + 16'h1;
            buf_lines_r <= 16'h0;
            scan_lines_r <= scan_lines_r + 16'h1;
         end else if (line_done) begin
            buf_lines_r <= buf_lines_r + 16'h1;
            scan_lines_r <= scan_lines_r + 16'h1;
         end else if (halt && scan_active_r && buf_lines_r != 16'h0) begin
            // the cut line is dropped, whole lines are released
            buf_release <= 1'b1;
            buf_info <= '{lines: buf_lines_r, buf_id: buf_id_r};
            buf_id_r <= buf_id_r + 16'h1;
            buf_lines_r <= 16'h0;
         end
      end
   end

   // words go out on one channel with their line slot
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         dma_valid <= 1'b0;
         dma_word <= '0;
      end else begin
         dma_valid <= scan_active_r && pix_valid && !line_boundary;
         dma_word.data <= pix_data;
         dma_word.slot <= cfg_r[`LSAG_CFG_FLIP] ?
            buf_cap_r - 16'h1 - buf_lines_r : buf_lines_r;
      end
   end

   // ==========================================================
   // encoder rate tools
   logic [15:0] div_cnt_r;
   logic [31:0] acc_r;
   logic div_hit, md_hit, speed;
   assign speed = cfg_r[`LSAG_CFG_SPEED];
   assign div_hit = speed && encoder_event && div_cnt_r + 16'h1 >= div_n_r;
   // exact accumulator, no rounding loss over time
   assign md_hit = acc_r >= {16'h0, div_r} && div_r != 16'h0;
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn)
         div_cnt_r <= 16'h0;
      else if (div_hit)
         div_cnt_r <= 16'h0;
      else if (speed && encoder_event)
         div_cnt_r <= div_cnt_r + 16'h1;
   end

   // up to one trigger a cycle; a large ratio drains as a burst
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn)
         acc_r <= 32'h0;
      else if (!speed || !cfg_r[`LSAG_CFG_MULDIV])
         acc_r <= 32'h0;
      else
         acc_r <= acc_r + (encoder_event ? {16'h0, mul_r} : 32'h0)
            - (md_hit ? {16'h0, div_r} : 32'h0);
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn)
         camera_trigger <= 1'b0;
      else
         camera_trigger <= cfg_r[`LSAG_CFG_MULDIV] ? md_hit && speed
            : div_hit;
   end

   // ==========================================================
   // checks
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   property p_gate_open;
      state_r == lsag_pkg::ST_PEND && line_boundary && !halt |=> gate_open;
   endproperty
   a_gate_open: assert property (p_gate_open)
      else $error("gate did not open at boundary");
   property p_begin_ignored;
      state_r == lsag_pkg::ST_SCAN && !close_now && !halt |=>
         state_r == lsag_pkg::ST_SCAN;
   endproperty
   a_begin_ignored: assert property (p_begin_ignored)
      else $error("scan left without a close cause");
   property p_halt_close;
      halt |=> !gate_open && state_r == lsag_pkg::ST_IDLE;
   endproperty
   a_halt_close: assert property (p_halt_close)
      else $error("halt did not close gate");
   property p_count_close;
      gate_open && line_boundary && count_done && !halt |=> !gate_open;
   endproperty
   a_count_close: assert property (p_count_close)
      else $error("gate open past line count");
   property p_finish_idle;
      !scan_active_r |=> !finish_pend_r;
   endproperty
   a_finish_idle: assert property (p_finish_idle)
      else $error("finish taken outside scan");
   property p_flag_gate;
      scan_active_r == (state_r == lsag_pkg::ST_SCAN);
   endproperty
   a_flag_gate: assert property (p_flag_gate)
      else $error("scan flag differs from gate");
   property p_new_buf;
      open_now |=> buf_lines_r == 16'h0;
   endproperty
   a_new_buf: assert property (p_new_buf)
      else $error("scan did not start a new buffer");
   property p_whole;
      buf_release |-> buf_info.lines <= buf_cap_r && buf_info.lines != 16'h0;
   endproperty
   a_whole: assert property (p_whole)
      else $error("released buffer line count wrong");
   property p_final_rel;
      line_done && close_now |=> buf_release;
   endproperty
   a_final_rel: assert property (p_final_rel)
      else $error("final buffer not released");
   property p_div;
      div_hit |-> encoder_event && div_cnt_r == div_n_r - 16'h1 ##1
         camera_trigger || cfg_r[`LSAG_CFG_MULDIV];
   endproperty
   a_div: assert property (p_div)
      else $error("divider trigger without Nth event");
   c_scan_count: cover property (open_now ##[1:200] buf_release);
   c_full: cover property (full_now && !close_now);
   c_flip: cover property (dma_valid && cfg_r[`LSAG_CFG_FLIP]);
endmodule

// >>> src/lsag_defs.svh
// register map, field positions, reset values of the line scan gate
`ifndef LSAG_DEFS_SVH
`define LSAG_DEFS_SVH
`define LSAG_OFS_CMD      8'h00
`define LSAG_OFS_CFG      8'h04
`define LSAG_OFS_LINES    8'h08
`define LSAG_OFS_BUFCAP   8'h0c
`define LSAG_OFS_DIVN     8'h10
`define LSAG_OFS_MUL      8'h14
`define LSAG_OFS_DIV      8'h18
`define LSAG_OFS_STATUS   8'h1c
`define LSAG_CMD_ARM      0
`define LSAG_CMD_HALT     1
`define LSAG_CMD_BEGIN    2
`define LSAG_CMD_FINISH   3
`define LSAG_CFG_BSRC_LO  0
`define LSAG_CFG_FSRC_LO  2
`define LSAG_CFG_FLIP     4
`define LSAG_CFG_SPEED    5
`define LSAG_CFG_MULDIV   6
`define LSAG_CFG_W        7
`define LSAG_CFG_RST      7'h00
`define LSAG_LINES_RST    16'h0001
`define LSAG_BUFCAP_RST   16'h0010
`define LSAG_RATE_RST     16'h0001
`endif

// >>> src/lsag_pkg.sv
// types shared by the line scan acquisition gate
package lsag_pkg;
   typedef enum logic [1:0] {
      BSRC_IMMEDIATE = 2'h0, BSRC_COMMAND = 2'h1,
      BSRC_LINE_ONE = 2'h2, BSRC_LINE_TWO = 2'h3
   } lsag_bsrc_t;
   typedef enum logic [1:0] {
      FSRC_COMMAND = 2'h0, FSRC_COUNT = 2'h1,
      FSRC_LINE_ONE = 2'h2, FSRC_LINE_TWO = 2'h3
   } lsag_fsrc_t;
   // gray along idle -> armed -> pending -> scanning
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00, ST_ARMED = 2'b01, ST_PEND = 2'b11, ST_SCAN = 2'b10
   } lsag_state_t;
   typedef struct packed {
      logic [31:0] data;
      logic [15:0] slot;
   } lsag_word_t;
   typedef struct packed {
      logic [15:0] lines;
      logic [15:0] buf_id;
   } lsag_release_t;
endpackage

// >>> verification/lsag_line_source.sv
// camera line stream and host buffer consumer facing the gate
`timescale 1ns/100ps
module lsag_line_source #(
   parameter int LINE_LEN = 12                    // cycles per camera line
) (
   input wire logic clk_sys,                      // system clock
   input wire logic resetn,                       // async reset, active low
   input wire logic clr,                          // clears the tallies
   input wire logic gate_open,                    // acquisition gate
   input wire logic dma_valid,                    // word delivered
   input wire lsag_pkg::lsag_word_t dma_word,     // word and slot
   input wire logic buf_release,                  // buffer handed over
   input wire lsag_pkg::lsag_release_t buf_info,  // handed buffer info
   output logic line_boundary,                    // line start pulse
   output logic pix_valid,                        // line word valid
   output logic [31:0] pix_data,                  // line word
   output int ph,                                 // line phase
   output int open_ph,                            // phase when gate rose
   output int shut_ph,                            // phase when gate fell
   output int first_slot,                         // slot of first word
   output int n_words,                            // words since clear
   output int n_rel,                              // releases since clear
   output int sum_lines,                          // lines released
   output int last_id,                            // id of last release
   output int bad_words                           // words not as sent
);
   logic gate_q;
   bit got;
   // ===========================================================
   // camera side
   // free running: boundary, one gap cycle, four words, idle tail
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         ph <= 0;
      end else begin
         ph <= (ph == LINE_LEN - 1) ? 0 : ph + 1;
      end
   end
   assign line_boundary = resetn && (ph == 0);
   assign pix_valid = (ph >= 2) && (ph <= 5);
   // idle data changes every cycle so a stale word can never match
   assign pix_data = pix_valid ? {24'h5a5a5a, 8'(ph)} : {24'ha5c3e1, 8'(ph)};
   // ===========================================================
   // host side
   // tallies of delivered words and buffers, phases of gate edges
   always_ff @(posedge clk_sys) begin
      gate_q <= gate_open;
      if (gate_open && !gate_q) open_ph <= ph;
      if (!gate_open && gate_q) shut_ph <= ph;
      if (clr) begin
         n_words <= 0;
         n_rel <= 0;
         sum_lines <= 0;
         bad_words <= 0;
         got <= 1'b0;
      end else begin
         if (dma_valid) begin
            n_words <= n_words + 1;
            // the word sent one cycle back must arrive unchanged
            if (dma_word.data !== {24'h5a5a5a, 8'(ph - 1)})
               bad_words <= bad_words + 1;
            if (!got) first_slot <= int'(dma_word.slot);
            got <= 1'b1;
         end
         if (buf_release) begin
            n_rel <= n_rel + 1;
            sum_lines <= sum_lines + int'(buf_info.lines);
            last_id <= int'(buf_info.buf_id);
         end
      end
   end
endmodule

// >>> verification/testbench.sv
// self-checking bench for the line scan acquisition gate
`timescale 1ns/100ps
`include "lsag_defs.svh"
module testbench;
   localparam int LL = 12;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, rdat;
   logic pready, pslverr, rerr, line_boundary, pix_valid;
   logic [31:0] pix_data;
   logic ev_one = 1'b0;
   logic ev_two = 1'b0;
   logic enc = 1'b0;
   logic clr = 1'b1;
   logic camera_trigger, gate_open, dma_valid, buf_release;
   lsag_pkg::lsag_word_t dma_word;
   lsag_pkg::lsag_release_t buf_info;
   int ph, open_ph, shut_ph, first_slot, n_words, n_rel, sum_lines, last_id;
   int fails = 0;
   int n_compared = 0;
   int n_trig = 0;
   int keep_id, bad_words;
   always #25 clk_sys = ~clk_sys;
   // triggers counted between clears
   always @(posedge clk_sys) n_trig <= clr ? 0 : n_trig + camera_trigger;
   lsag_top DUT (.clk_sys(clk_sys), .resetn(resetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .line_boundary(line_boundary), .pix_valid(pix_valid),
      .pix_data(pix_data), .line_input_one_event(ev_one),
      .line_input_two_event(ev_two), .encoder_event(enc),
      .camera_trigger(camera_trigger), .gate_open(gate_open),
      .dma_valid(dma_valid), .dma_word(dma_word),
      .buf_release(buf_release), .buf_info(buf_info));
   lsag_line_source #(.LINE_LEN(LL)) far_side (.clk_sys(clk_sys),
      .resetn(resetn), .clr(clr), .gate_open(gate_open),
      .dma_valid(dma_valid), .dma_word(dma_word), .buf_release(buf_release),
      .buf_info(buf_info), .line_boundary(line_boundary),
      .pix_valid(pix_valid), .pix_data(pix_data), .ph(ph), .open_ph(open_ph),
      .shut_ph(shut_ph), .first_slot(first_slot), .n_words(n_words),
      .n_rel(n_rel), .sum_lines(sum_lines), .last_id(last_id),
      .bad_words(bad_words));
   // ===========================================================
   // shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   // one apb transfer; request held until pready is seen high
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chk(32'(n < 20), 32'h1);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(a, 1'b1, d);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                         input logic err);
      apb(a, 1'b0, 32'h0000_0000);
      chk(rdat, e);
      chk({31'h0, rerr}, {31'h0, err});
   endtask
   task automatic cmd(input int b);
      wr(`LSAG_OFS_CMD, 32'(1 << b));
   endtask
   task automatic clear();
      @(posedge clk_sys);
      clr <= 1'b1;
      @(posedge clk_sys);
      clr <= 1'b0;
   endtask
   task automatic setup(input logic [31:0] cfg, input int lines, input int cap);
      wr(`LSAG_OFS_CFG, cfg);
      wr(`LSAG_OFS_LINES, 32'(lines));
      wr(`LSAG_OFS_BUFCAP, 32'(cap));
      clear();
      cmd(`LSAG_CMD_ARM);
   endtask
   // which: 0 encoder, 1 line one, 2 line two; five cycles apart
   task automatic pulse(input int which, input int times);
      repeat (times) begin
         @(posedge clk_sys);
         case (which)
            0: enc <= 1'b1;
            1: ev_one <= 1'b1;
            default: ev_two <= 1'b1;
         endcase
         @(posedge clk_sys);
         enc <= 1'b0;
         ev_one <= 1'b0;
         ev_two <= 1'b0;
         repeat (3) @(posedge clk_sys);
      end
   endtask
   task automatic wait_gate(input logic v, input int lim);
      int n;
      n = 0;
      while (gate_open !== v && n < lim) begin
         @(posedge clk_sys);
         n++;
      end
      chk({31'h0, gate_open}, {31'h0, v});
      repeat (2) @(posedge clk_sys);
   endtask
   task automatic wait_rel(input int k, input int lim);
      int n;
      n = 0;
      while (n_rel < k && n < lim) begin
         @(posedge clk_sys);
         n++;
      end
      chk(n_rel, k);
   endtask
   // ===========================================================
   // scenarios
   task automatic t_regs();
      rd_chk(`LSAG_OFS_CFG, 32'h0, 1'b0);
      rd_chk(`LSAG_OFS_LINES, 32'h1, 1'b0);
      rd_chk(`LSAG_OFS_BUFCAP, 32'h10, 1'b0);
      rd_chk(`LSAG_OFS_DIVN, 32'h1, 1'b0);
      rd_chk(`LSAG_OFS_MUL, 32'h1, 1'b0);
      rd_chk(`LSAG_OFS_DIV, 32'h1, 1'b0);
      rd_chk(8'h20, 32'h0, 1'b1);
      wr(`LSAG_OFS_CFG, 32'hffff_ffff);
      rd_chk(`LSAG_OFS_CFG, 32'h7f, 1'b0);
      $display("register test done");
   endtask
   // command begin, count end; begin during a scan must not latch
   task automatic t_count();
      setup(32'h5, 3, 16);
      repeat (3 * LL) @(posedge clk_sys);
      chk({31'h0, gate_open}, 32'h0);
      rd_chk(`LSAG_OFS_STATUS, 32'h12, 1'b0);
      cmd(`LSAG_CMD_BEGIN);
      wait_gate(1'b1, LL + 4);
      wait_rel(1, 6 * LL);
      chk(open_ph, 1);
      chk(first_slot, 0);
      chk(sum_lines, 3);
      chk(n_words, 12);
      chk(bad_words, 0);
      keep_id = last_id;
      cmd(`LSAG_CMD_BEGIN);
      wait_gate(1'b1, LL + 4);
      cmd(`LSAG_CMD_BEGIN);
      wait_rel(2, 6 * LL);
      chk(32'(last_id != keep_id), 32'h1);
      repeat (2 * LL) @(posedge clk_sys);
      chk({31'h0, gate_open}, 32'h0);
      chk(sum_lines, 6);
      cmd(`LSAG_CMD_HALT);
      $display("count scan test done");
   endtask
   task automatic t_fill();
      setup(32'h5, 5, 2);
      cmd(`LSAG_CMD_BEGIN);
      wait_rel(1, 5 * LL);
      chk(sum_lines, 2);
      wait_rel(3, 6 * LL);
      chk(sum_lines, 5);
      cmd(`LSAG_CMD_HALT);
      setup(32'h15, 2, 4);
      cmd(`LSAG_CMD_BEGIN);
      wait_rel(1, 5 * LL);
      chk(first_slot, 3);
      cmd(`LSAG_CMD_HALT);
      $display("buffer fill test done");
   endtask
   // line one begins, line two finishes
   task automatic t_event();
      setup(32'he, 1, 16);
      pulse(2, 1);
      repeat (2 * LL) @(posedge clk_sys);
      chk({31'h0, gate_open}, 32'h0);
      pulse(1, 1);
      wait_gate(1'b1, LL + 8);
      pulse(1, 1);
      repeat (2 * LL) @(posedge clk_sys);
      chk({31'h0, gate_open}, 32'h1);
      pulse(2, 1);
      wait_gate(1'b0, LL + 8);
      chk(shut_ph, 1);
      chk(n_rel, 1);
      cmd(`LSAG_CMD_HALT);
      // line two begins, line one finishes; the other line is ignored
      setup(32'hb, 1, 16);
      pulse(1, 1);
      repeat (2 * LL) @(posedge clk_sys);
      chk({31'h0, gate_open}, 32'h0);
      pulse(2, 1);
      wait_gate(1'b1, LL + 8);
      pulse(1, 1);
      wait_gate(1'b0, LL + 8);
      cmd(`LSAG_CMD_HALT);
      $display("event scan test done");
   endtask
   task automatic t_imm();
      setup(32'h0, 1, 16);
      wait_gate(1'b1, LL + 8);
      chk(open_ph, 1);
      pulse(2, 1);
      repeat (3 * LL) @(posedge clk_sys);
      chk({31'h0, gate_open}, 32'h1);
      cmd(`LSAG_CMD_FINISH);
      wait_gate(1'b0, LL + 8);
      chk(shut_ph, 1);
      wait_gate(1'b1, LL + 8);
      repeat (2 * LL) @(posedge clk_sys);
      cmd(`LSAG_CMD_HALT);
      wait_gate(1'b0, 4);
      chk(n_rel, 2);
      $display("immediate scan test done");
   endtask
   task automatic t_enc();
      wr(`LSAG_OFS_CFG, 32'h0);
      clear();
      pulse(0, 4);
      chk(n_trig, 0);
      wr(`LSAG_OFS_DIVN, 32'h3);
      wr(`LSAG_OFS_CFG, 32'h20);
      clear();
      pulse(0, 9);
      chk(n_trig, 3);
      wr(`LSAG_OFS_MUL, 32'h3);
      wr(`LSAG_OFS_DIV, 32'h2);
      wr(`LSAG_OFS_CFG, 32'h60);
      clear();
      pulse(0, 8);
      repeat (4) @(posedge clk_sys);
      chk(n_trig, 12);
      $display("encoder test done");
   endtask
   task automatic wrap_up();
      $display("compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // ===========================================================
   // main sequence and watchdog
   initial begin
      repeat (5) @(posedge clk_sys);
      resetn <= 1'b1;
      clr <= 1'b0;
      t_regs();
      t_count();
      t_fill();
      t_event();
      t_imm();
      t_enc();
      wrap_up();
   end
   // whole run needs about a thousand cycles; the 40000-cycle limit leaves a wide margin
   initial begin
      #(40000 * 50);
      fails++;
      wrap_up();
   end
endmodule
